// ==== core/rtcca_defs.vh ====
// Register offsets, field positions and counter limits of the clock block.
`ifndef RTCCA_DEFS_VH
`define RTCCA_DEFS_VH

// ============================================================
// Register offsets
`define RTCCA_OFS_SEC 4'h0
`define RTCCA_OFS_MIN 4'h1
`define RTCCA_OFS_HOUR 4'h2
`define RTCCA_OFS_WDAY 4'h3
`define RTCCA_OFS_DATE 4'h4
`define RTCCA_OFS_MONTH 4'h5
`define RTCCA_OFS_YEAR 4'h6
`define RTCCA_OFS_A1_SEC 4'h7
`define RTCCA_OFS_A1_MIN 4'h8
`define RTCCA_OFS_A1_HOUR 4'h9
`define RTCCA_OFS_A1_DAY 4'ha
`define RTCCA_OFS_A2_MIN 4'hb
`define RTCCA_OFS_A2_HOUR 4'hc
`define RTCCA_OFS_A2_DAY 4'hd

// ============================================================
// Field positions
`define RTCCA_MASK_BIT 7
`define RTCCA_FMT12_BIT 6
`define RTCCA_PM_BIT 5
`define RTCCA_DAYSEL_BIT 6

// ============================================================
// Counter limits and reset values, BCD
`define RTCCA_BCD_59 8'h59
`define RTCCA_BCD_23 8'h23
`define RTCCA_BCD_12 8'h12
`define RTCCA_BCD_11 8'h11
`define RTCCA_BCD_99 8'h99
`define RTCCA_BCD_31 8'h31
`define RTCCA_BCD_30 8'h30
`define RTCCA_BCD_29 8'h29
`define RTCCA_BCD_28 8'h28
`define RTCCA_BCD_01 8'h01
`define RTCCA_WDAY_MAX 3'h7
`define RTCCA_RST_ZERO 8'h00

`endif

// ==== core/rtcca_bcd_inc.v ====
// BCD increment with wrap from a maximum to a minimum value.
`timescale 1ns/1ns
module rtcca_bcd_inc (
    // Operand and bounds
    input wire [7:0] i_val,
    input wire [7:0] i_max,
    input wire [7:0] i_min,
    // Result
    output reg [7:0] o_next,
    output reg o_wrap
);
    always @* begin
        o_wrap = (i_val == i_max);
        if (o_wrap) begin
            o_next = i_min;
        end else if (i_val[3:0] == 4'h9) begin
            o_next = {i_val[7:4] + 4'h1, 4'h0};
        end else begin
            o_next = {i_val[7:4], i_val[3:0] + 4'h1};
        end
    end
endmodule

// ==== core/rtcca_alarm_match.v ====
// Alarm comparison for one alarm set against the running time.
`timescale 1ns/1ns
module rtcca_alarm_match (
    // Alarm set, seconds used only when i_has_sec is high
    input wire i_has_sec,
    input wire [7:0] i_a_sec,
    input wire [7:0] i_a_min,
    input wire [7:0] i_a_hour,
    input wire [7:0] i_a_day,
    // Time after the update
    input wire [6:0] i_sec,
    input wire [6:0] i_min,
    input wire [6:0] i_hour,
    input wire [2:0] i_wday,
    input wire [5:0] i_date,
    // Result
    output reg o_hit
);
    reg [3:0] masks;
    reg s_eq;
    reg m_eq;
    reg h_eq;
    reg d_eq;
    always @* begin
        masks = {i_a_day[7], i_a_hour[7], i_a_min[7],
            i_has_sec ? i_a_sec[7] : 1'b1};
        s_eq = i_has_sec ? (i_a_sec[6:0] == i_sec) : (i_sec == 7'h00); // R21
        m_eq = (i_a_min[6:0] == i_min);
        h_eq = (i_a_hour[6:0] == i_hour);
        d_eq = i_a_day[6] ? (i_a_day[2:0] == i_wday) // R18
            : (i_a_day[5:0] == i_date);
        // Alarm two has its seconds slot forced to one, so its patterns
        // are the odd codes; the odd codes d, 9 and 1 from alarm one are ignored.
        case (masks) // R20 R21
            4'hf: o_hit = i_has_sec ? 1'b1 : s_eq;
            4'he: o_hit = s_eq;
            4'hd: o_hit = !i_has_sec && s_eq && m_eq;
            4'hc: o_hit = s_eq && m_eq;
            4'h9: o_hit = !i_has_sec && s_eq && m_eq && h_eq;
            4'h8: o_hit = s_eq && m_eq && h_eq;
            4'h0: o_hit = s_eq && m_eq && h_eq && d_eq;
            4'h1: o_hit = !i_has_sec && s_eq && m_eq && h_eq && d_eq;
            default: o_hit = 1'b0;
        endcase
    end
endmodule

// ==== core/rtcca_top.v ====
// Time, calendar and alarm registers of the clock block.
// Function
// [R1] Every time field is held as BCD tens and units.
// [R2] Seconds run 00 to 59; wrap carries into minutes.
// [R3] Minutes run 00 to 59; wrap carries into hours.
// [R4] Hours wrap 23 to 00 or 11PM to 12AM, carrying to date and weekday.
// [R5] Hours bit 6 selects format: 0 is 24-hour, 1 is 12-hour.
// [R6] In 12-hour mode bit 5 is PM; otherwise hour twenties.
// [R7] Host selects the hour format before writing hours.
// [R8] Weekday counts 1 to 7 then back to 1 on day carry.
// [R9] Host keeps weekday meanings sequential.
// [R10] Host writes only valid values; invalid values are undefined.
// [R11] Date, month and year are kept in BCD.
// [R12] Date caps at month length, with February 29 in leap years.
// [R13] Date past month end returns to 1 and bumps month.
// [R14] Month runs 1 to 12; wrap bumps the year.
// [R15] Year runs 00 to 99; multiples of four are leap.
// [R16] Alarm one mask bits live in bit 7 of its four registers.
// [R17] Alarm two mask bits live in bit 7 of its three registers.
// [R18] Day select bit 6 picks weekday or date comparison.
// [R19] Alarms compare only at the per-second update and set flags.
// [R20] Alarm one rate follows its four mask bits.
// [R21] Alarm two rate follows its three mask bits.
// [R22] Seconds advance once per tick; zero bits read zero. A tick in the same cycle as a register write is lost.
`timescale 1ns/1ns
`include "rtcca_defs.vh"
module rtcca_top (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst_n,
    // One second tick from the oscillator divider, asynchronous
    input wire i_tick_1hz,
    // Register port from the serial engine, same clock
    input wire [3:0] i_reg_addr,
    input wire i_reg_wr,
    input wire [7:0] i_reg_wdata,
    output reg [7:0] o_reg_rdata,
    // Alarm events, one-cycle pulses to the status logic
    output reg o_alarm_one_flag,
    output reg o_alarm_two_flag
);
    // ============================================================
    // Reset release
    reg rst_meta_q;
    reg rst_sync_q;
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    wire rst_n = rst_sync_q;

    // ============================================================
    // Tick synchroniser; a change counts when stages two and three agree.
    reg tick_s1_q;
    reg tick_s2_q;
    reg tick_s3_q;
    reg tick_lvl_q;
    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_s1_q <= 1'b0;
            tick_s2_q <= 1'b0;
            tick_s3_q <= 1'b0;
            tick_lvl_q <= 1'b0;
        end else begin
            tick_s1_q <= i_tick_1hz;
            tick_s2_q <= tick_s1_q;
            tick_s3_q <= tick_s2_q;
            if (tick_s2_q == tick_s3_q) begin
                tick_lvl_q <= tick_s3_q;
            end
        end
    end
    wire tick = (tick_s2_q == tick_s3_q) && tick_s3_q && !tick_lvl_q;

    // ============================================================
    // Register storage
    reg [6:0] sec_q;
    reg [6:0] min_q;
    reg [6:0] hour_q;
    reg [2:0] wday_q;
    reg [5:0] date_q;
    reg [4:0] month_q;
    reg [7:0] year_q;
    reg [7:0] alarm_q [7:13];

    // ============================================================
    // Counter chain
    wire [7:0] sec_nx;
    wire [7:0] min_nx;
    wire [7:0] hr_nx;
    wire [7:0] date_nx;
    wire [7:0] mon_nx;
    wire [7:0] yr_nx;
    wire sec_w;
    wire min_w;
    wire hr_w;
    wire date_w;
    wire mon_w;
    wire fmt12 = hour_q[`RTCCA_FMT12_BIT];
    wire [7:0] hr12 = {3'h0, hour_q[4:0]};
    wire [7:0] hr_cur = fmt12 ? hr12 : {1'b0, hour_q};
    reg [7:0] hr_max;
    reg [7:0] hr_min;
    reg [7:0] mlen;
    reg leap;

    // Leap test on a BCD year: tens parity and units pattern.
    function is_leap;
        input [7:0] y;
        begin
            if (y[4]) begin
                is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6); // R15
            end else begin
                is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4)
                    || (y[3:0] == 4'h8);
            end
        end
    endfunction

    always @* begin
        leap = is_leap(year_q);
        case (month_q) // R12
            5'h04, 5'h06, 5'h09, 5'h11: mlen = `RTCCA_BCD_30;
            5'h02: mlen = leap ? `RTCCA_BCD_29 : `RTCCA_BCD_28;
            default: mlen = `RTCCA_BCD_31;
        endcase
        // 12-hour counts 12,01..11: from 12 go to 01, wrap at 11.
        if (fmt12) begin
            hr_max = (hr12 == `RTCCA_BCD_12) ? 8'hff : `RTCCA_BCD_11;
            hr_min = `RTCCA_BCD_12;
        end else begin
            hr_max = `RTCCA_BCD_23;
            hr_min = `RTCCA_RST_ZERO;
        end
    end

    rtcca_bcd_inc u_sec (
        .i_val({1'b0, sec_q}),
        .i_max(`RTCCA_BCD_59),
        .i_min(`RTCCA_RST_ZERO),
        .o_next(sec_nx),
        .o_wrap(sec_w)
    );
    rtcca_bcd_inc u_min (
        .i_val({1'b0, min_q}),
        .i_max(`RTCCA_BCD_59),
        .i_min(`RTCCA_RST_ZERO),
        .o_next(min_nx),
        .o_wrap(min_w)
    );
    rtcca_bcd_inc u_hour (
        .i_val((fmt12 && hr12 == `RTCCA_BCD_12) ? `RTCCA_RST_ZERO : hr_cur),
        .i_max(hr_max),
        .i_min(hr_min),
        .o_next(hr_nx),
        .o_wrap(hr_w)
    );
    rtcca_bcd_inc u_date (
        .i_val({2'h0, date_q}),
        .i_max(mlen),
        .i_min(`RTCCA_BCD_01),
        .o_next(date_nx),
        .o_wrap(date_w)
    );
    rtcca_bcd_inc u_mon (
        .i_val({3'h0, month_q}),
        .i_max(`RTCCA_BCD_12),
        .i_min(`RTCCA_BCD_01),
        .o_next(mon_nx),
        .o_wrap(mon_w)
    );
    rtcca_bcd_inc u_year (
        .i_val(year_q),
        .i_max(`RTCCA_BCD_99),
        .i_min(`RTCCA_RST_ZERO),
        .o_next(yr_nx),
        .o_wrap()
    );

    // PM flips when 11 steps to 12 in 12-hour mode.
    wire pm_flip = fmt12 && (hr12 == `RTCCA_BCD_11);
    wire day_carry = fmt12 ? (pm_flip && hour_q[`RTCCA_PM_BIT]) : hr_w;

    // Time after this tick's increment, used for alarm matching.
    reg [6:0] sec_d;
    reg [6:0] min_d;
    reg [6:0] hour_d;
    reg [2:0] wday_d;
    reg [5:0] date_d;
    reg [4:0] month_d;
    reg [7:0] year_d;
    always @* begin
        sec_d = sec_nx[6:0]; // R22 R2
        min_d = min_q;
        hour_d = hour_q;
        wday_d = wday_q;
        date_d = date_q;
        month_d = month_q;
        year_d = year_q;
        if (sec_w) begin
            min_d = min_nx[6:0]; // R3
            if (min_w) begin
                if (fmt12) begin
                    hour_d = {1'b1, hour_q[5] ^ pm_flip, hr_nx[4:0]}; // R6
                end else begin
                    hour_d = {1'b0, hr_nx[5:0]}; // R5
                end
                if (day_carry) begin // R4
                    wday_d = (wday_q == `RTCCA_WDAY_MAX) ? 3'h1
                        : wday_q + 3'h1; // R8
                    date_d = date_nx[5:0]; // R13
                    if (date_w) begin
                        month_d = mon_nx[4:0]; // R14
                        if (mon_w) begin
                            year_d = yr_nx; // R11
                        end
                    end
                end
            end
        end
    end

    // ============================================================
    // Register writes and per-second update; a write wins over a tick.
    integer k;
    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_q <= 7'h00;
            min_q <= 7'h00;
            hour_q <= 7'h00;
            wday_q <= 3'h1;
            date_q <= 6'h01;
            month_q <= 5'h01;
            year_q <= `RTCCA_RST_ZERO;
            for (k = 7; k <= 13; k = k + 1) begin
                alarm_q[k] <= `RTCCA_RST_ZERO;
            end
        end else if (i_reg_wr) begin
            case (i_reg_addr) // R1 R16 R17
                `RTCCA_OFS_SEC: sec_q <= i_reg_wdata[6:0];
                `RTCCA_OFS_MIN: min_q <= i_reg_wdata[6:0];
                `RTCCA_OFS_HOUR: hour_q <= i_reg_wdata[6:0];
                `RTCCA_OFS_WDAY: wday_q <= i_reg_wdata[2:0];
                `RTCCA_OFS_DATE: date_q <= i_reg_wdata[5:0];
                `RTCCA_OFS_MONTH: month_q <= i_reg_wdata[4:0];
                `RTCCA_OFS_YEAR: year_q <= i_reg_wdata;
                4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd:
                    alarm_q[i_reg_addr] <= i_reg_wdata;
                default: ;
            endcase
        end else if (tick) begin
            sec_q <= sec_d;
            min_q <= min_d;
            hour_q <= hour_d;
            wday_q <= wday_d;
            date_q <= date_d;
            month_q <= month_d;
            year_q <= year_d;
        end
    end

    // ============================================================
    // Alarm compare at the once-per-second update
    wire hit_one;
    wire hit_two;
    rtcca_alarm_match u_alarm_one (
        .i_has_sec(1'b1),
        .i_a_sec(alarm_q[7]),
        .i_a_min(alarm_q[8]),
        .i_a_hour(alarm_q[9]),
        .i_a_day(alarm_q[10]),
        .i_sec(sec_d),
        .i_min(min_d),
        .i_hour(hour_d),
        .i_wday(wday_d),
        .i_date(date_d),
        .o_hit(hit_one)
    );
    rtcca_alarm_match u_alarm_two (
        .i_has_sec(1'b0),
        .i_a_sec(`RTCCA_RST_ZERO),
        .i_a_min(alarm_q[11]),
        .i_a_hour(alarm_q[12]),
        .i_a_day(alarm_q[13]),
        .i_sec(sec_d),
        .i_min(min_d),
        .i_hour(hour_d),
        .i_wday(wday_d),
        .i_date(date_d),
        .o_hit(hit_two)
    );

    // Compare is skipped on a tick lost to a write, since time did not move.
    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_alarm_one_flag <= 1'b0;
            o_alarm_two_flag <= 1'b0;
        end else begin
            o_alarm_one_flag <= tick && !i_reg_wr && hit_one; // R19
            o_alarm_two_flag <= tick && !i_reg_wr && hit_two; // R19
        end
    end

    // ============================================================
    // Read data, registered; unused bits read zero.
    always @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_reg_rdata <= `RTCCA_RST_ZERO;
        end else begin
            case (i_reg_addr) // R22
                `RTCCA_OFS_SEC: o_reg_rdata <= {1'b0, sec_q};
                `RTCCA_OFS_MIN: o_reg_rdata <= {1'b0, min_q};
                `RTCCA_OFS_HOUR: o_reg_rdata <= {1'b0, hour_q};
                `RTCCA_OFS_WDAY: o_reg_rdata <= {5'h00, wday_q};
                `RTCCA_OFS_DATE: o_reg_rdata <= {2'h0, date_q};
                `RTCCA_OFS_MONTH: o_reg_rdata <= {3'h0, month_q};
                `RTCCA_OFS_YEAR: o_reg_rdata <= year_q;
                4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd:
                    o_reg_rdata <= alarm_q[i_reg_addr];
                default: o_reg_rdata <= `RTCCA_RST_ZERO;
            endcase
        end
    end
endmodule

// ==== verification/rtcca_checker.sv ====
// Assertion checker for the clock, calendar and alarm register block.
`timescale 1ns/1ns
module rtcca_checker (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst_n,
    // Tick and register port
    input wire i_tick_1hz,
    input wire [3:0] i_reg_addr,
    input wire i_reg_wr,
    input wire [7:0] i_reg_wdata,
    input wire [7:0] o_reg_rdata,
    // Alarm pulses
    input wire o_alarm_one_flag,
    input wire o_alarm_two_flag
);
    // ============================================================
    // Read-back ranges, one cycle after the address is presented, then alarm pulse checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    AST_SEC_MIN_BCD: assert property (i_reg_addr <= 4'h1 |=>
        o_reg_rdata[7:4] <= 4'h5 && o_reg_rdata[3:0] <= 4'h9)
        else $error("seconds or minutes read outside 00 to 59");
    AST_HOUR_RANGE: assert property (i_reg_addr == 4'h2 |=>
        !o_reg_rdata[7] && o_reg_rdata[3:0] <= 4'h9 && (o_reg_rdata[6] ?
        (o_reg_rdata[4:0] != 5'h00 && o_reg_rdata[4:0] <= 5'h12) :
        o_reg_rdata[5:0] <= 6'h23))
        else $error("hours read outside its format range");
    AST_WDAY_RANGE: assert property (i_reg_addr == 4'h3 |=>
        o_reg_rdata inside {[8'h01:8'h07]})
        else $error("weekday read outside 1 to 7");
    AST_DATE_RANGE: assert property (i_reg_addr == 4'h4 |=>
        o_reg_rdata inside {[8'h01:8'h09], [8'h10:8'h19], [8'h20:8'h29],
        [8'h30:8'h31]})
        else $error("date read outside 01 to 31");
    AST_MONTH_RANGE: assert property (i_reg_addr == 4'h5 |=>
        o_reg_rdata inside {[8'h01:8'h09], [8'h10:8'h12]})
        else $error("month read outside 01 to 12");
    AST_YEAR_BCD: assert property (i_reg_addr == 4'h6 |=>
        o_reg_rdata[7:4] <= 4'h9 && o_reg_rdata[3:0] <= 4'h9)
        else $error("year read is not BCD");
    AST_UNMAPPED_ZERO: assert property (i_reg_addr >= 4'he |=>
        o_reg_rdata == 8'h00)
        else $error("unmapped offset read nonzero");
    AST_ALARM_RW: assert property ((i_reg_wr &&
        i_reg_addr inside {[4'h7:4'hd]}) ##1 (!i_reg_wr &&
        $stable(i_reg_addr)) |=> o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("alarm register did not read back as written");
    AST_FLAG_PULSE: assert property (o_alarm_one_flag ||
        o_alarm_two_flag |=> !o_alarm_one_flag && !o_alarm_two_flag)
        else $error("alarm pulse longer than one cycle");
    AST_FLAG_AFTER_TICK: assert property (o_alarm_one_flag ||
        o_alarm_two_flag |-> $past(i_tick_1hz, 2))
        else $error("alarm pulse without a preceding tick");
endmodule

bind rtcca_top rtcca_checker u_chk (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_tick_1hz(i_tick_1hz), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_alarm_one_flag(o_alarm_one_flag),
    .o_alarm_two_flag(o_alarm_two_flag));

// ==== verification/rtcca_host_model.sv ====
// Host model driving the register port and the one second tick.
`timescale 1ns/1ns
module rtcca_host_model (
    // Clock
    input wire logic i_core_clk,
    // Register port toward the block
    output logic [3:0] o_reg_addr,
    output logic o_reg_wr,
    output logic [7:0] o_reg_wdata,
    input wire logic [7:0] i_reg_rdata,
    // Tick from the oscillator divider
    output logic o_tick_1hz
);
    initial begin
        o_reg_addr = 4'h0;
        o_reg_wr = 1'b0;
        o_reg_wdata = 8'h00;
        o_tick_1hz = 1'b0;
    end

    // ============================================================
    // Requests change after a falling edge and hold over one rising.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        o_reg_addr = a;
        o_reg_wdata = d;
        o_reg_wr = 1'b1;
        @(negedge i_core_clk);
        o_reg_wr = 1'b0;
        // Stale data must not look valid once the strobe is gone.
        o_reg_wdata = ~d;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge i_core_clk);
        o_reg_addr = a;
        @(negedge i_core_clk);
        d = i_reg_rdata;
    endtask

    // Time is {sec, min, hour, weekday, date, month, year}, valid only.
    task automatic load(input logic [55:0] t);
        wr(4'h2, t[38] ? 8'h52 : 8'h00);
        for (int i = 0; i < 7; i++)
            wr(i[3:0], t[55-8*i -: 8]);
    endtask

    // Level held six cycles each way, above the two-cycle minimum.
    task automatic tick();
        @(negedge i_core_clk);
        o_tick_1hz = 1'b1;
        repeat (6) @(negedge i_core_clk);
        o_tick_1hz = 1'b0;
        repeat (6) @(negedge i_core_clk);
    endtask
endmodule

// ==== verification/rtcca_top_bench.sv ====
// Self-checking bench for the clock, calendar and alarm register block.
`timescale 1ns/1ns
module rtcca_top_bench;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    wire tick_1hz;
    wire [3:0] reg_addr;
    wire reg_wr;
    wire [7:0] reg_wdata;
    wire [7:0] reg_rdata;
    wire alarm_one_flag;
    wire alarm_two_flag;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    int f1 = 0;
    int f2 = 0;
    logic [7:0] got;
    localparam logic [55:0] S1 = 56'h09_30_10_01_15_06_20;
    localparam logic [55:0] S2 = 56'h59_29_10_01_15_06_20;

    rtcca_top u_dut (.i_core_clk(core_clk), .i_rst_n(rst_n),
        .i_tick_1hz(tick_1hz), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
        .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
        .o_alarm_one_flag(alarm_one_flag),
        .o_alarm_two_flag(alarm_two_flag));
    rtcca_host_model u_host (.i_core_clk(core_clk), .o_reg_addr(reg_addr),
        .o_reg_wr(reg_wr), .o_reg_wdata(reg_wdata),
        .i_reg_rdata(reg_rdata), .o_tick_1hz(tick_1hz));

    initial forever #20 core_clk = ~core_clk;

    // Flags are counted on the falling edge, where they have settled.
    always @(negedge core_clk) begin
        cyc++;
        if (alarm_one_flag === 1'b1)
            f1++;
        if (alarm_two_flag === 1'b1)
            f2++;
        if (cyc == 5000) begin
            error_cnt++;
            summarize();
        end
    end

    // ============================================================
    // Shared checks
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic summarize();
        if (error_cnt == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic expect_time(input logic [55:0] t);
        for (int i = 0; i < 7; i++) begin
            u_host.rd(i[3:0], got);
            chk(got, t[55-8*i -: 8]);
        end
    endtask

    task automatic run_case(input logic [55:0] s, input logic [55:0] e);
        u_host.load(s);
        u_host.tick();
        expect_time(e);
    endtask

    task automatic alarm_case(input logic [31:0] a1, input logic [23:0] a2,
        input logic [55:0] s, input int e1, input int e2);
        for (int i = 0; i < 4; i++)
            u_host.wr(4'h7 + i[3:0], a1[31-8*i -: 8]);
        for (int i = 0; i < 3; i++)
            u_host.wr(4'hb + i[3:0], a2[23-8*i -: 8]);
        u_host.rd(4'ha, got);
        chk(got, a1[7:0]);
        u_host.rd(4'hd, got);
        chk(got, a2[7:0]);
        u_host.load(s);
        f1 = 0;
        f2 = 0;
        u_host.tick();
        chk(f1[7:0], e1[7:0]);
        chk(f2[7:0], e2[7:0]);
    endtask

    // ============================================================
    // Main sequence
    initial begin
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        expect_time(56'h00_00_00_01_01_01_00);
        for (int i = 7; i < 14; i++) begin
            u_host.rd(i[3:0], got);
            chk(got, 8'h00);
        end
        u_host.wr(4'he, 8'hff);
        u_host.rd(4'he, got);
        chk(got, 8'h00);
        u_host.rd(4'hf, got);
        chk(got, 8'h00);
        run_case(56'h59_59_23_07_31_12_99, 56'h0000_0001_010100);
        run_case(56'h09_00_00_01_01_01_00, 56'h10_00_00_01_01_01_00);
        run_case(56'h59_59_23_03_28_02_04, 56'h00_00_00_04_29_02_04);
        run_case(56'h59_59_23_04_29_02_04, 56'h00_00_00_05_01_03_04);
        run_case(56'h59_59_23_04_28_02_01, 56'h00_00_00_05_01_03_01);
        run_case(56'h59_59_23_01_28_02_00, 56'h00_00_00_02_29_02_00);
        run_case(56'h59_59_23_04_30_04_19, 56'h00_00_00_05_01_05_19);
        run_case(56'h59_59_23_04_30_01_19, 56'h00_00_00_05_31_01_19);
        run_case(56'h59_59_71_02_31_07_10, 56'h00_00_52_03_01_08_10);
        run_case(56'h59_59_51_02_15_07_10, 56'h00_00_72_02_15_07_10);
        run_case(56'h59_59_52_02_15_07_10, 56'h00_00_41_02_15_07_10);
        run_case(56'h59_59_11_02_15_07_10, 56'h00_00_12_02_15_07_10);
        run_case(56'h59_59_19_02_15_07_10, 56'h00_00_20_02_15_07_10);
        alarm_case(32'h80808080, 24'h000000, S1, 1, 0);
        alarm_case(32'h10808080, 24'h808080, S1, 1, 0);
        alarm_case(32'h11808080, 24'h808080, S2, 0, 1);
        alarm_case(32'h00308080, 24'h308080, S2, 1, 1);
        alarm_case(32'h00301080, 24'h301080, S2, 1, 1);
        alarm_case(32'h00301015, 24'h301041, S2, 1, 1);
        alarm_case(32'h00301016, 24'h301042, S2, 0, 0);
        alarm_case(32'h80008080, 24'h800080, S2, 0, 0);
        summarize();
    end
endmodule
